// ---- src/pwu_pkg.sv ----
// Constants and register map of the pin wake unit
package pwu_pkg;
   localparam int unsigned PWU_NPIN = 6;
   localparam int unsigned PWU_AW = 8;
   // Register byte offsets
   localparam logic [7:0] PWU_SC_OFF = 8'h00;
   localparam logic [7:0] PWU_PE_OFF = 8'h04;
   localparam logic [7:0] PWU_ES_OFF = 8'h08;
   localparam logic [7:0] PWU_EVS_OFF = 8'h0C;
   localparam logic [7:0] PWU_EVM_OFF = 8'h10;
   // Status and control field positions
   localparam int unsigned PWU_SC_MODE = 0;
   localparam int unsigned PWU_SC_IE = 1;
   localparam int unsigned PWU_SC_ACK = 2;
   localparam int unsigned PWU_SC_FLAG = 3;
   // Implemented pin positions 0,1,2,4,5
   localparam logic [5:0] PWU_PIN_MASK = 6'h37;
   // Event status bits
   localparam int unsigned PWU_EV_FLAG = 0;
   localparam int unsigned PWU_EV_STOP = 1;
   localparam int unsigned PWU_NEV = 2;
   // Reset values
   localparam logic [5:0] PWU_PIN_RST = 6'h00;
   localparam logic [1:0] PWU_EV_RST = 2'h0;
   localparam logic [31:0] PWU_ZERO32 = 32'h0000_0000;
endpackage

// ---- src/pwu_stop_catch.sv ----
// Asynchronous catch of a wake condition while the clock is stopped
`timescale 1ns/1ps
module pwu_stop_catch (
   input wire logic det_i,   // Wake condition, clockless
   input wire logic clr_n_i, // Active-low clear, also reset
   output logic wake_o       // Caught wake, level
);
   import pwu_pkg::*;

   // The condition itself is the clock: no bus clock exists in stop
   always_ff @(posedge det_i or negedge clr_n_i) begin
      if (!clr_n_i) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= 1'b1;
      end
   end
endmodule

// ---- src/pwu_top.sv ----
// Pin wake unit: pin-change detection, shared flag and APB registers
//
// Overview of operation
// - Per-pin enable gates flag setting
// - Mode bit picks edge or edge-plus-level
// - Polarity bit picks falling/low or rising/high
// - Edges detected from successive clock samples
// - Deasserted level seen before edge counts
// - Edge mode: valid edge sets flag
// - Level mode: edge or level sets flag
// - Request when flag and enable set
// - Flag is read-only to software
// - Acknowledge write clears flag, reads zero
// - Level mode: ack clears only when deasserted
// - Keeps running in wait mode
// - Stop mode detects asynchronously and wakes, only with interrupt enable set
// - Debug halt does not stop detection
// - Enabling pins drives no pull device
`timescale 1ns/1ps
module pwu_top #(
   parameter int unsigned NPIN = pwu_pkg::PWU_NPIN
) (
   input wire logic mclk_i,                        // Bus clock, 25 MHz
   input wire logic rstn_i,                        // Async reset, active low
   input wire logic psel_i,                        // APB select
   input wire logic penable_i,                     // APB enable
   input wire logic pwrite_i,                      // APB write
   input wire logic [pwu_pkg::PWU_AW-1:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i,               // APB write data
   output logic [31:0] prdata_o,                   // APB read data
   output logic pready_o,                          // APB ready
   output logic pslverr_o,                         // APB error, unmapped
   input wire logic [NPIN-1:0] wake_input_pin_i,   // Wake input pins
   input wire logic stop_i,                        // Stop mode, clock gated
   output logic irq_o,                             // Interrupt request, level
   output logic wake_o                             // Stop wake request
);
   import pwu_pkg::*;

   typedef struct packed {
      logic mode;
      logic ie;
      logic flag;
      logic [NPIN-1:0] pe;
      logic [NPIN-1:0] es;
      logic [NPIN-1:0] armed;
      logic [PWU_NEV-1:0] evs;
      logic [PWU_NEV-1:0] evm;
      logic wk_s1;
      logic wk_s2;
      logic wk_seen;
      logic stop_clr;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
   } pwu_state_t;

   pwu_state_t st_q;
   pwu_state_t st_d;

   logic [NPIN-1:0] asrt;
   logic [NPIN-1:0] edge_hit;
   logic [NPIN-1:0] lvl_hit;
   logic set_flag;
   logic stop_det;
   logic stop_wake;
   logic acc;
   logic wr;
   logic ack_wr;
   logic ack_ok;
   logic mapped;
   logic [31:0] rd_val;

   // Per-pin asserted level and detection
   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_pin
         assign asrt[g] = st_q.es[g] ? wake_input_pin_i[g] : ~wake_input_pin_i[g];
         // Armed only after a deasserted sample, so a pin enabled while held
         // asserted never reports an edge
         assign edge_hit[g] = st_q.pe[g] & st_q.armed[g] & asrt[g];
         assign lvl_hit[g] = st_q.pe[g] & asrt[g];
      end
   endgenerate

   // Edge mode ignores levels; level mode takes either
   assign set_flag = (|edge_hit) | (st_q.mode & (|lvl_hit)) | stop_wake;

   // Stop detection: edge mode needs the pin armed by its last deasserted
   // sample, so a pin held asserted into stop cannot fake a wake
   assign stop_det = stop_i & st_q.ie & (|(lvl_hit & (st_q.armed | {NPIN{st_q.mode}})));
   assign stop_wake = st_q.wk_s2 & ~st_q.wk_seen;

   pwu_stop_catch u_catch (
      .det_i(stop_det),
      .clr_n_i(rstn_i & ~st_q.stop_clr),
      .wake_o(wake_o)
   );

   assign acc = psel_i & penable_i & st_q.pready;
   assign wr = acc & pwrite_i;
   assign ack_wr = wr & (paddr_i == PWU_SC_OFF) & pwdata_i[PWU_SC_ACK];
   // Level mode refuses the clear while any enabled pin is asserted
   assign ack_ok = ~st_q.mode | ~(|lvl_hit);

   always_comb begin
      mapped = 1'b1;
      rd_val = PWU_ZERO32;
      case (paddr_i)
         PWU_SC_OFF: begin
            // Acknowledge bit reads as zero
            rd_val[PWU_SC_FLAG] = st_q.flag;
            rd_val[PWU_SC_IE] = st_q.ie;
            rd_val[PWU_SC_MODE] = st_q.mode;
         end
         PWU_PE_OFF: begin
            rd_val[NPIN-1:0] = st_q.pe;
         end
         PWU_ES_OFF: begin
            rd_val[NPIN-1:0] = st_q.es;
         end
         PWU_EVS_OFF: begin
            rd_val[PWU_NEV-1:0] = st_q.evs;
         end
         PWU_EVM_OFF: begin
            rd_val[PWU_NEV-1:0] = st_q.evm;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      st_d = st_q;
      // Detection runs every cycle regardless of wait or debug halt
      st_d.armed = st_q.pe & ~asrt;
      // Stop wake crossing; stop_clr releases the catcher after stop ends
      st_d.wk_s1 = wake_o;
      st_d.wk_s2 = st_q.wk_s1;
      st_d.wk_seen = st_q.wk_s2;
      st_d.stop_clr = ~stop_i & st_q.wk_s2;
      // Flag: set wins over acknowledge
      if (set_flag) begin
         st_d.flag = 1'b1;
      end else if (ack_wr & ack_ok) begin
         st_d.flag = 1'b0;
      end
      if (wr) begin
         case (paddr_i)
            PWU_SC_OFF: begin
               // Flag bit of the write data is ignored
               st_d.mode = pwdata_i[PWU_SC_MODE];
               st_d.ie = pwdata_i[PWU_SC_IE];
            end
            PWU_PE_OFF: begin
               st_d.pe = pwdata_i[NPIN-1:0] & PWU_PIN_MASK[NPIN-1:0];
            end
            PWU_ES_OFF: begin
               st_d.es = pwdata_i[NPIN-1:0] & PWU_PIN_MASK[NPIN-1:0];
            end
            PWU_EVS_OFF: begin
               st_d.evs = st_q.evs & ~pwdata_i[PWU_NEV-1:0];
            end
            PWU_EVM_OFF: begin
               st_d.evm = pwdata_i[PWU_NEV-1:0];
            end
            default: begin
               st_d.evm = st_q.evm;
            end
         endcase
      end
      // Sticky events set after the write-one-to-clear so a set wins
      if (set_flag & ~st_q.flag) begin
         st_d.evs[PWU_EV_FLAG] = 1'b1;
      end
      if (stop_wake) begin
         st_d.evs[PWU_EV_STOP] = 1'b1;
      end
      // One wait state per access keeps all outputs registered
      st_d.pready = psel_i & penable_i & ~st_q.pready;
      st_d.pslverr = psel_i & penable_i & ~st_q.pready & ~mapped;
      if (psel_i & penable_i & ~st_q.pready & ~pwrite_i) begin
         st_d.prdata = rd_val;
      end else begin
         st_d.prdata = PWU_ZERO32;
      end
      st_d.irq = (st_d.flag & st_d.ie) | (|(st_d.evs & st_d.evm));
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Pull controls live in the port block; nothing here drives them
   assign prdata_o = st_q.prdata;
   assign pready_o = st_q.pready;
   assign pslverr_o = st_q.pslverr;
   assign irq_o = st_q.irq;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);

   // Detection and flag setting
   chk_edge_sets_flag: assert property (
      (|edge_hit) |=> st_q.flag)
      else $error("edge did not set flag");

   chk_level_sets_flag: assert property (
      (st_q.mode & (|lvl_hit)) |=> st_q.flag)
      else $error("level did not set flag");

   chk_edge_mode_level: assert property (
      (~st_q.mode & ~st_q.flag & ~(|edge_hit) & ~stop_wake & ~ack_wr) |=> ~st_q.flag)
      else $error("flag set without edge");

   chk_disabled_pin: assert property (
      (st_q.pe == '0 & ~stop_wake & ~st_q.flag) |=> ~st_q.flag)
      else $error("disabled pins set flag");

   chk_armed_first: assert property (
      (st_q.pe[0] & asrt[0] & $past(asrt[0])) |-> ~edge_hit[0])
      else $error("edge without deasserted sample");

   chk_level_disabled: assert property (
      (st_q.mode & ~st_q.flag & ~stop_wake & ((st_q.pe & asrt) == '0))
      |=> ~st_q.flag)
      else $error("level mode flagged without enabled asserted pin");

   chk_fall_sets_flag: assert property (
      (st_q.pe[0] & ~st_q.es[0] & $past(wake_input_pin_i[0]) & ~wake_input_pin_i[0]
         & $past(st_q.pe[0]) & $stable(st_q.es[0]))
      |=> st_q.flag)
      else $error("falling edge missed");

   chk_rise_sets_flag: assert property (
      (st_q.pe[4] & st_q.es[4] & ~$past(wake_input_pin_i[4]) & wake_input_pin_i[4]
         & $past(st_q.pe[4]) & $stable(st_q.es[4]))
      |=> st_q.flag)
      else $error("rising edge missed");

   chk_stable_no_edge: assert property (
      ($stable(wake_input_pin_i) & $stable(st_q.pe) & $stable(st_q.es)) |-> ~(|edge_hit))
      else $error("edge without pin change");

   chk_rise_ignores_low: assert property (
      (st_q.es[4] & ~wake_input_pin_i[4]) |-> ~lvl_hit[4])
      else $error("low level seen as asserted on rising pin");

   chk_fall_ignores_high: assert property (
      (~st_q.es[0] & wake_input_pin_i[0]) |-> ~lvl_hit[0])
      else $error("high level seen as asserted on falling pin");

   // Stop mode catch and hand-back
   chk_stop_sets_flag: assert property (
      stop_wake |=> st_q.flag)
      else $error("stop wake did not set flag");

   chk_stop_event: assert property (
      stop_wake |=> st_q.evs[PWU_EV_STOP])
      else $error("stop wake event lost");

   chk_catch_cleared: assert property (
      st_q.stop_clr |-> ~wake_o)
      else $error("wake held through clear");

   // Request output
   chk_irq_follows: assert property (
      (st_q.flag & st_q.ie) |-> irq_o)
      else $error("irq missing");

   chk_irq_exact: assert property (
      (~(st_q.flag & st_q.ie) & ((st_q.evs & st_q.evm) == '0)) |-> ~irq_o)
      else $error("irq without cause");

   chk_irq_masked: assert property (
      (~st_q.ie & (st_q.evm == '0)) |-> ~irq_o)
      else $error("masked request reached the output");

   // Acknowledge and software access
   chk_ack_clears: assert property (
      (ack_wr & ~st_q.mode & ~set_flag) |=> ~st_q.flag)
      else $error("ack did not clear flag");

   chk_ack_refused: assert property (
      (ack_wr & st_q.mode & (|lvl_hit) & st_q.flag) |=> st_q.flag)
      else $error("ack cleared asserted level");

   chk_flag_ro: assert property (
      (wr & paddr_i == PWU_SC_OFF & ~pwdata_i[PWU_SC_ACK] & st_q.flag) |=> st_q.flag)
      else $error("write changed flag");

   chk_ack_reads0: assert property (
      (psel_i & penable_i & ~st_q.pready & ~pwrite_i & paddr_i == PWU_SC_OFF)
      |=> (st_q.prdata[PWU_SC_ACK] == 1'b0) && st_q.pready)
      else $error("ack bit read as one");

   chk_ack_level_ok: assert property (
      (ack_wr & st_q.mode & ~(|lvl_hit) & ~set_flag) |=> ~st_q.flag)
      else $error("ack refused with pins deasserted");

   chk_flag_sticky: assert property (
      (st_q.flag & ~ack_wr) |=> st_q.flag)
      else $error("flag dropped without ack");

   chk_set_beats_ack: assert property (
      (ack_wr & set_flag) |=> st_q.flag)
      else $error("acknowledge beat a new event");

   // Register contents
   chk_unimpl_zero: assert property (
      ((st_q.pe | st_q.es) & ~PWU_PIN_MASK[NPIN-1:0]) == '0)
      else $error("unimplemented pin bit set");

   chk_pe_write: assert property (
      (wr & (paddr_i == PWU_PE_OFF))
      |=> (st_q.pe == ($past(pwdata_i[NPIN-1:0]) & PWU_PIN_MASK[NPIN-1:0])))
      else $error("pin enable write lost");

   chk_es_write: assert property (
      (wr & (paddr_i == PWU_ES_OFF))
      |=> (st_q.es == ($past(pwdata_i[NPIN-1:0]) & PWU_PIN_MASK[NPIN-1:0])))
      else $error("polarity write lost");

   chk_mode_write: assert property (
      (wr & (paddr_i == PWU_SC_OFF))
      |=> ((st_q.mode == $past(pwdata_i[PWU_SC_MODE])) && (st_q.ie == $past(pwdata_i[PWU_SC_IE]))))
      else $error("control write lost");

   chk_upper_zero: assert property (
      (psel_i & penable_i & ~st_q.pready & ~pwrite_i)
      |=> (st_q.prdata[31:NPIN] == '0))
      else $error("unimplemented read bits set");

   // Main scenarios
   cov_edge_flag: cover property ((|edge_hit) & ~st_q.mode ##1 st_q.irq);
   cov_ack_refused: cover property (ack_wr & st_q.mode & (|lvl_hit));
   cov_stop_wake: cover property (stop_wake);
   cov_level_flag: cover property (st_q.mode & (|lvl_hit) & ~st_q.flag ##1 st_q.flag);
   cov_rise_edge: cover property ((|(edge_hit & st_q.es)) ##1 st_q.flag);
endmodule

// ---- test/pwu_pin_model.sv ----
// Model of the external switches that drive the wake input pins
`timescale 1ns/1ps
module pwu_pin_model (
   input wire logic mclk_i,          // Bus clock
   input wire logic [5:0] level_i,   // Commanded switch levels
   output logic [5:0] pin_o          // Pin levels seen by the unit
);
   // Switches drive both levels, the unit supplies no pull
   initial pin_o = 6'h3F;
   always @(posedge mclk_i) begin
      pin_o <= level_i;
   end
endmodule

// ---- test/pwu_top_tb_top.sv ----
// Register-level regression of the pin wake unit
`timescale 1ns/1ps
module pwu_top_tb_top;
   import pwu_pkg::*;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic stop = 1'b0;
   logic irq;
   logic wake;
   logic [5:0] lvl = 6'h3F;
   logic [5:0] pins;
   logic [31:0] last_q;
   logic last_err;
   int errors = 0;
   int comparisons = 0;
   always #20 mclk_i = ~mclk_i;
   pwu_pin_model pwu_pin_model_inst (.mclk_i(mclk_i), .level_i(lvl), .pin_o(pins));
   pwu_top #(.NPIN(6)) pwu_top_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .wake_input_pin_i(pins), .stop_i(stop), .irq_o(irq), .wake_o(wake));
   task close_out();
      $display("Comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Pready is sampled before this edge's updates land, as a flop would
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      // No local limit: only the watchdog ends a stuck wait
      do begin
         @(posedge mclk_i);
      end while (pready !== 1'b1);
      last_q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(last_q, exp);
   endtask
   task irqchk(input logic exp);
      tick(3);
      chk({31'h0, irq}, {31'h0, exp});
   endtask
   initial begin
      #(40 * 3000);
      $display("ERROR %0t: watchdog expired", $time);
      errors++;
      close_out();
   end
   initial begin
      tick(20);
      rstn_i <= 1'b1;
      rd(PWU_SC_OFF, 32'h0000_0000);
      rd(PWU_PE_OFF, 32'h0000_0000);
      rd(PWU_ES_OFF, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      chk({31'h0, last_err}, 32'h0000_0001);
      // Safe bring-up order avoids a spurious request
      wr(PWU_SC_OFF, 32'h0000_0000);
      wr(PWU_ES_OFF, 32'h0000_0000);
      wr(PWU_PE_OFF, 32'h0000_00FF);
      rd(PWU_PE_OFF, 32'h0000_0037);
      wr(PWU_SC_OFF, 32'h0000_0004);
      wr(PWU_SC_OFF, 32'h0000_00FA);
      rd(PWU_SC_OFF, 32'h0000_0002);
      irqchk(1'b0);
      lvl <= 6'h3E;
      tick(5);
      rd(PWU_SC_OFF, 32'h0000_000A);
      irqchk(1'b1);
      wr(PWU_SC_OFF, 32'h0000_0006);
      rd(PWU_SC_OFF, 32'h0000_0002);
      irqchk(1'b0);
      // Disabled pin 0 and unimplemented pin 3 must not flag
      wr(PWU_PE_OFF, 32'h0000_0036);
      lvl <= 6'h3F;
      tick(5);
      lvl <= 6'h36;
      tick(5);
      rd(PWU_SC_OFF, 32'h0000_0002);
      wr(PWU_PE_OFF, 32'h0000_0037);
      wr(PWU_SC_OFF, 32'h0000_0003);
      tick(3);
      rd(PWU_SC_OFF, 32'h0000_000B);
      wr(PWU_SC_OFF, 32'h0000_0007);
      rd(PWU_SC_OFF, 32'h0000_000B);
      lvl <= 6'h3F;
      tick(5);
      wr(PWU_SC_OFF, 32'h0000_0007);
      rd(PWU_SC_OFF, 32'h0000_0003);
      // Pin 4 rising: the acknowledge discards any flag from the switch
      wr(PWU_SC_OFF, 32'h0000_0000);
      wr(PWU_ES_OFF, 32'h0000_0010);
      wr(PWU_SC_OFF, 32'h0000_0004);
      tick(3);
      rd(PWU_SC_OFF, 32'h0000_0000);
      rd(PWU_ES_OFF, 32'h0000_0010);
      lvl <= 6'h2F;
      tick(5);
      rd(PWU_SC_OFF, 32'h0000_0000);
      lvl <= 6'h3F;
      tick(5);
      rd(PWU_SC_OFF, 32'h0000_0008);
      rd(PWU_EVS_OFF, 32'h0000_0001);
      irqchk(1'b0);
      wr(PWU_EVM_OFF, 32'h0000_0001);
      irqchk(1'b1);
      wr(PWU_EVS_OFF, 32'h0000_0001);
      rd(PWU_EVS_OFF, 32'h0000_0000);
      irqchk(1'b0);
      wr(PWU_ES_OFF, 32'h0000_0000);
      wr(PWU_SC_OFF, 32'h0000_0006);
      rd(PWU_SC_OFF, 32'h0000_0002);
      chk({31'h0, wake}, 32'h0000_0000);
      stop <= 1'b1;
      lvl <= 6'h3E;
      tick(3);
      chk({31'h0, wake}, 32'h0000_0001);
      stop <= 1'b0;
      tick(8);
      rd(PWU_EVS_OFF, 32'h0000_0003);
      chk({31'h0, wake}, 32'h0000_0000);
      rd(PWU_SC_OFF, 32'h0000_000A);
      close_out();
   end
endmodule
